// ===== shared/dmdc_defs.svh
`ifndef DMDC_DEFS_SVH
`define DMDC_DEFS_SVH
// command encodings {csN, rasN, casN, weN}
`define DMDC_CMD_NOP      4'h7
`define DMDC_CMD_READ     4'h5
`define DMDC_CMD_WRITE    4'h4
`define DMDC_CMD_MRS      4'h0
`define DMDC_CMD_REF      4'h1
// mode register selects on bank address
`define DMDC_MR0          3'h0
`define DMDC_MR1          3'h1
`define DMDC_MR2          3'h2
`define DMDC_MR3          3'h3
// address bit positions
`define DMDC_A_DLLDIS     0
`define DMDC_A_MPREN      2
`define DMDC_A_AP         10
`define DMDC_A_BC         12
`define DMDC_A_DLLRST     8
// MR0 burst length field codes
`define DMDC_BL_FIXED8    2'h0
`define DMDC_BL_OTF       2'h1
`define DMDC_BL_FIXED4    2'h2
// MPR location for the calibration pattern
`define DMDC_MPR_LOC_CAL  2'h0
// calibration pattern, beat 0 in bit 0
`define DMDC_MPR_PATTERN  8'hAA
// reset values and burst beat counts
`define DMDC_RST_CL       4'h6
`define DMDC_RST_AL       4'h0
`define DMDC_BEATS_BL8    4'h8
`define DMDC_BEATS_BC4    4'h4
`endif

// ===== shared/dmdc_pkg.sv
package dmdc_pkg;
  typedef enum logic [2:0] {
    DMDC_OP_NONE,
    DMDC_OP_READ_ARRAY,
    DMDC_OP_READ_MPR,
    DMDC_OP_WRITE,
    DMDC_OP_MRS,
    DMDC_OP_OTHER
  } dmdc_op_t;

  typedef struct packed {
    logic       csN;
    logic       rasN;
    logic       casN;
    logic       weN;
    logic [2:0] bank;
    logic [15:0] addr;
  } dmdc_cmd_t;

  typedef struct packed {
    logic       valid;
    dmdc_op_t   op;
    logic [2:0] bank;
    logic [15:0] addr;
  } dmdc_dec_t;

  typedef struct packed {
    logic       mprEnable;
    logic [1:0] mprLoc;
    logic       dllOff;
    logic       dllReset;
    logic [1:0] burstMode;
    logic [3:0] casLatency;
    logic [3:0] addLatency;
  } dmdc_mode_t;

  typedef struct packed {
    logic       start;
    logic       mpr;
    logic       chop;
    logic       upperNibble;
    logic       autoPre;
  } dmdc_rd_t;
endpackage

// ===== hdl/dmdc_cmd_decode.sv
`timescale 1ns/1ps
`include "dmdc_defs.svh"
module dmdc_cmd_decode
(
  input  wire dmdc_pkg::dmdc_cmd_t cmd,
  input  wire logic                mprEnable,
  output      dmdc_pkg::dmdc_dec_t dec
);
  always_comb
  begin
    dec       = '0;
    dec.bank  = cmd.bank;
    dec.addr  = cmd.addr;
    if (cmd.csN)
    begin
      dec.valid = 1'b0;
      dec.op    = dmdc_pkg::DMDC_OP_NONE;
    end
    else
    begin
      unique case ({cmd.csN, cmd.rasN, cmd.casN, cmd.weN})
        `DMDC_CMD_NOP:
        begin
          dec.valid = 1'b0;
          dec.op    = dmdc_pkg::DMDC_OP_NONE;
        end
        `DMDC_CMD_READ:
        begin
          dec.valid = 1'b1;
          dec.op    = mprEnable ? dmdc_pkg::DMDC_OP_READ_MPR
                                : dmdc_pkg::DMDC_OP_READ_ARRAY;
        end
        `DMDC_CMD_WRITE:
        begin
          dec.valid = 1'b1;
          dec.op    = dmdc_pkg::DMDC_OP_WRITE;
        end
        `DMDC_CMD_MRS:
        begin
          dec.valid = 1'b1;
          dec.op    = dmdc_pkg::DMDC_OP_MRS;
        end
        default:
        begin
          dec.valid = 1'b1;
          dec.op    = dmdc_pkg::DMDC_OP_OTHER;
        end
      endcase
    end
  end
endmodule // dmdc_cmd_decode

// ===== hdl/dmdc_mpr_serializer.sv
`timescale 1ns/1ps
`include "dmdc_defs.svh"
module dmdc_mpr_serializer
#(
  parameter int DQ_BYTES = 2
)
(
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  input  wire logic                  start,
  input  wire logic                  chop,
  input  wire logic                  upperNibble,
  input  wire logic                  replicate,
  input  wire logic [1:0]            mprLoc,
  output      logic [8*DQ_BYTES-1:0] mprData,
  output      logic                  mprValid
);
  typedef struct packed {
    logic [3:0] beat;
    logic [3:0] left;
    logic [15:0] dq;
    logic       valid;
    logic       rep;
    logic       rfu;
  } dmdc_ser_st_t;

  dmdc_ser_st_t st_reg;
  dmdc_ser_st_t st_next;
  logic         bitNow;
  logic [7:0]   pattern;
  logic [2:0]   beatSel;
  logic         rfuSel;
  logic         repSel;

  // first beat leaves on the start edge itself, so no cycle is lost to the read latency
  assign beatSel = start ? ((chop && upperNibble) ? 3'h4 : 3'h0) : st_reg.beat[2:0];
  assign rfuSel  = start ? (mprLoc != `DMDC_MPR_LOC_CAL) : st_reg.rfu;
  assign repSel  = start ? replicate : st_reg.rep;
  // reserved locations return zero, a safe defined answer
  assign pattern = rfuSel ? 8'h00 : `DMDC_MPR_PATTERN;
  assign bitNow  = pattern[beatSel];

  always_comb
  begin
    st_next       = st_reg;
    st_next.valid = 1'b0;
    if (start || (st_reg.left != 4'h0))
    begin
      st_next.valid = 1'b1;
      st_next.beat  = {1'b0, beatSel} + 4'h1;
      st_next.left  = start ? ((chop ? `DMDC_BEATS_BC4 : `DMDC_BEATS_BL8) - 4'h1)
                            : (st_reg.left - 4'h1);
      st_next.rep   = repSel;
      st_next.rfu   = rfuSel;
      st_next.dq    = '0;
      for (int b = 0; b < DQ_BYTES; b++)
      begin
        st_next.dq[8*b]      = bitNow;
        st_next.dq[8*b+1 +: 7] = repSel ? {7{bitNow}} : 7'h00;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign mprData  = st_reg.dq[8*DQ_BYTES-1:0];
  assign mprValid = st_reg.valid;
endmodule // dmdc_mpr_serializer

// ===== hdl/dmdc_mode_ctrl.sv
`timescale 1ns/1ps
`include "dmdc_defs.svh"
// Notes on behaviour
// - while readout mode is on, every read goes to the register, MR3 A1:0 select
// - in readout mode a read with auto precharge does no precharge
// - with MR3 A2 clear, reads and writes use the array normally
// - lowest line of each byte carries the bit; others copy it or zero
// - readout ignores bank and upper column bits; controller sends A1:0 as 00
// - BL8 beats 0 to 7; chop picks beats 0-3 or 4-7 by A2
// - burst chop comes from MR0 or on the fly through A12
// - readout uses normal read latency; controller waits for DLL lock
// - location 00 returns 0,1,0,1 pattern; other locations reserved
// - chip select low with other strobes high is a no-operation
// - chip select high starts nothing new; running work continues
// - MR1 A0 set turns the DLL off until written back to zero
// - DLL-off supports only CL 6 with CWL 6
// - DLL-off read strobe starts at AL+CL-1 instead of AL+CL
module dmdc_mode_ctrl
#(
  parameter int DQ_BYTES = 2,
  parameter int LAT_W    = 6
)
(
  input  wire core_clk,
  input  wire resetn,
  input  wire dmdc_pkg::dmdc_cmd_t cmdIn,
  input  wire logic                cke,
  input  wire logic                mprReplicate,
  output      logic [8*DQ_BYTES-1:0] dqOut,
  output      logic [8*DQ_BYTES-1:0] dqOe,
  output      logic                dqsOe,
  output      dmdc_pkg::dmdc_mode_t modeOut,
  output      logic                arrayReadStart,
  output      logic                arrayWriteStart,
  output      logic                autoPrechargeReq,
  output      logic                dllResetPulse,
  output      logic                latencyUnsupported,
  output      logic                illegalInMpr
);
  typedef struct packed {
    dmdc_pkg::dmdc_mode_t mode;
    logic [LAT_W-1:0]     rdDelay;
    logic                 rdPending;
    dmdc_pkg::dmdc_rd_t   rd;
    logic                 arrRd;
    logic                 arrWr;
    logic                 autoPre;
    logic                 dllRst;
    logic                 illegal;
    logic [3:0]           cwl;
  } dmdc_ctl_st_t;

  dmdc_ctl_st_t        st_reg;
  dmdc_ctl_st_t        st_next;
  dmdc_pkg::dmdc_dec_t dec;
  logic                mprStart;
  logic [8*DQ_BYTES-1:0] mprData;
  logic                mprValid;
  logic [LAT_W-1:0]    readLat;
  logic                chopNow;

  dmdc_cmd_decode u_decode
  (
    .cmd       (cmdIn),
    .mprEnable (st_reg.mode.mprEnable),
    .dec       (dec)
  );

  // dll off shortens read latency by one cycle
  always_comb
  begin
    readLat = LAT_W'(st_reg.mode.addLatency) + LAT_W'(st_reg.mode.casLatency);
    if (st_reg.mode.dllOff)
      readLat = readLat - LAT_W'(1);
  end

  // chop from MR0 fixed setting or A12 when on the fly is enabled
  always_comb
  begin
    unique case (st_reg.mode.burstMode)
      `DMDC_BL_FIXED4: chopNow = 1'b1;
      `DMDC_BL_OTF:    chopNow = ~dec.addr[`DMDC_A_BC];
      default:         chopNow = 1'b0;
    endcase
  end

  always_comb
  begin
    st_next          = st_reg;
    st_next.arrRd    = 1'b0;
    st_next.arrWr    = 1'b0;
    st_next.autoPre  = 1'b0;
    st_next.dllRst   = 1'b0;
    st_next.illegal  = 1'b0;
    st_next.rd.start = 1'b0;
    if (st_reg.rdPending)
    begin
      // fire one cycle early: array and serializer each take a cycle to launch
      if (st_reg.rdDelay <= LAT_W'(2))
      begin
        st_next.rdPending = 1'b0;
        st_next.rd.start  = st_reg.rd.mpr;
        st_next.arrRd     = ~st_reg.rd.mpr;
        st_next.autoPre   = st_reg.rd.autoPre;
      end
      else
        st_next.rdDelay = st_reg.rdDelay - LAT_W'(1);
    end
    // commands are only taken with cke high; running bursts continue regardless
    if (cke && dec.valid)
    begin
      unique case (dec.op)
        dmdc_pkg::DMDC_OP_READ_MPR:
        begin
          st_next.rdPending      = 1'b1;
          st_next.rdDelay        = readLat;
          st_next.rd.mpr         = 1'b1;
          st_next.rd.chop        = chopNow;
          st_next.rd.upperNibble = dec.addr[`DMDC_A_MPREN];
          st_next.rd.autoPre     = 1'b0;
          // bank and other column bits are not looked at here
        end
        dmdc_pkg::DMDC_OP_READ_ARRAY:
        begin
          st_next.rdPending      = 1'b1;
          st_next.rdDelay        = readLat;
          st_next.rd.mpr         = 1'b0;
          st_next.rd.chop        = chopNow;
          st_next.rd.upperNibble = 1'b0;
          st_next.rd.autoPre     = dec.addr[`DMDC_A_AP];
        end
        dmdc_pkg::DMDC_OP_WRITE:
        begin
          st_next.arrWr   = ~st_reg.mode.mprEnable;
          st_next.illegal = st_reg.mode.mprEnable;
        end
        dmdc_pkg::DMDC_OP_MRS:
        begin
          unique case (dec.bank)
            `DMDC_MR0:
            begin
              st_next.mode.burstMode  = dec.addr[1:0];
              st_next.mode.casLatency = {dec.addr[2], dec.addr[6:4]};
              st_next.dllRst          = dec.addr[`DMDC_A_DLLRST];
              st_next.mode.dllReset   = dec.addr[`DMDC_A_DLLRST];
            end
            `DMDC_MR1:
            begin
              st_next.mode.dllOff     = dec.addr[`DMDC_A_DLLDIS];
              st_next.mode.addLatency = {2'h0, dec.addr[4:3]};
            end
            `DMDC_MR2:
              st_next.cwl = {1'b0, dec.addr[5:3]} + 4'h5;
            `DMDC_MR3:
            begin
              st_next.mode.mprEnable = dec.addr[`DMDC_A_MPREN];
              st_next.mode.mprLoc    = dec.addr[1:0];
            end
            default:
            begin
              st_next.mode = st_reg.mode;
            end
          endcase
        end
        default:
          st_next.illegal = st_reg.mode.mprEnable;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg                 <= '0;
      st_reg.mode.casLatency <= `DMDC_RST_CL;
      st_reg.mode.addLatency <= `DMDC_RST_AL;
      st_reg.cwl             <= `DMDC_RST_CL;
    end
    else
      st_reg <= st_next;
  end

  assign mprStart = st_reg.rd.start;

  dmdc_mpr_serializer #(
    .DQ_BYTES (DQ_BYTES)
  ) u_mpr (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .start       (mprStart),
    .chop        (st_reg.rd.chop),
    .upperNibble (st_reg.rd.upperNibble),
    .replicate   (mprReplicate),
    .mprLoc      (st_reg.mode.mprLoc),
    .mprData     (mprData),
    .mprValid    (mprValid)
  );

  assign dqOut            = mprData;
  assign dqOe             = {(8*DQ_BYTES){mprValid}};
  assign dqsOe            = mprValid;
  assign modeOut          = st_reg.mode;
  assign arrayReadStart   = st_reg.arrRd;
  assign arrayWriteStart  = st_reg.arrWr;
  assign autoPrechargeReq = st_reg.autoPre;
  assign dllResetPulse    = st_reg.dllRst;
  assign illegalInMpr     = st_reg.illegal;
  // only CL 6 / CWL 6 is honoured with the dll off
  assign latencyUnsupported = st_reg.mode.dllOff &&
    ((st_reg.mode.casLatency != `DMDC_RST_CL) || (st_reg.cwl != `DMDC_RST_CL));
endmodule // dmdc_mode_ctrl

// ===== tb/dmdc_mode_ctrl_monitor.sv
`timescale 1ns/1ps
`include "dmdc_defs.svh"
module dmdc_mode_ctrl_monitor
(
  input wire                       core_clk,
  input wire                       resetn,
  input wire dmdc_pkg::dmdc_cmd_t  cmdIn,
  input wire logic                 cke,
  input wire logic                 mprReplicate,
  input wire logic [15:0]          dqOut,
  input wire logic [15:0]          dqOe,
  input wire dmdc_pkg::dmdc_mode_t modeOut,
  input wire logic                 arrayReadStart,
  input wire logic                 arrayWriteStart,
  input wire logic                 autoPrechargeReq,
  input wire logic                 illegalInMpr
);
  logic [3:0] op;
  logic       tk;
  logic       rd;
  logic       mrs;
  logic [4:0] lat;
  logic [4:0] since;
  logic       chop;
  logic [1:0] loc;
  logic [2:0] beat;
  assign op  = {cmdIn.csN, cmdIn.rasN, cmdIn.casN, cmdIn.weN};
  assign tk  = cke && !cmdIn.csN;
  assign rd  = tk && op == `DMDC_CMD_READ;
  assign mrs = tk && op == `DMDC_CMD_MRS;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // no reset needed: only read after a read command, which sets them
  always_ff @(posedge core_clk)
  begin
    since <= rd ? 5'h0 : since + 5'h1;
    beat  <= dqOe[0] ? beat + 3'h1 : 3'h0;
    if (rd)
    begin
      lat  <= {1'b0, modeOut.addLatency} + {1'b0, modeOut.casLatency} - {4'h0, modeOut.dllOff};
      chop <= modeOut.burstMode == `DMDC_BL_FIXED4 ||
              (modeOut.burstMode == `DMDC_BL_OTF && !cmdIn.addr[`DMDC_A_BC]);
      loc  <= modeOut.mprLoc;
    end
  end
  a_mpr_mode_bit: assert property (mrs && cmdIn.bank == `DMDC_MR3 |=>
    modeOut.mprEnable == $past(cmdIn.addr[2])) else $error("mpr enable wrong");
  a_mpr_no_precharge: assert property (modeOut.mprEnable |-> !autoPrechargeReq)
    else $error("precharge in mpr");
  a_mpr_write_refused: assert property (modeOut.mprEnable && tk && op == `DMDC_CMD_WRITE
    |=> illegalInMpr && !arrayWriteStart) else $error("write not refused");
  a_lane_copy: assert property (dqOe[0] |-> dqOut[15:8] == dqOut[7:0] &&
    dqOut[7:1] == (mprReplicate ? {7{dqOut[0]}} : 7'h00)) else $error("lanes wrong");
  a_read_latency: assert property ($rose(dqOe[0]) |-> since == lat)
    else $error("mpr latency wrong");
  a_array_latency: assert property (arrayReadStart |-> since == lat - 5'h1)
    else $error("array latency wrong");
  a_burst_eight: assert property ($rose(dqOe[0]) && !chop |-> dqOe[0] [*8] ##1 !dqOe[0])
    else $error("bl8 length wrong");
  a_burst_chop: assert property ($rose(dqOe[0]) && chop |-> dqOe[0] [*4] ##1 !dqOe[0])
    else $error("chop length wrong");
  a_cal_pattern: assert property (dqOe[0] |-> dqOut[0] == (loc == 2'h0 && beat[0]))
    else $error("pattern wrong");
  a_idle_no_effect: assert property (cke && (cmdIn.csN || op == `DMDC_CMD_NOP) |=>
    $stable({modeOut.mprEnable, modeOut.dllOff, modeOut.casLatency}) && !illegalInMpr)
    else $error("idle had effect");
  a_dll_off_bit: assert property (mrs && cmdIn.bank == `DMDC_MR1 |=>
    modeOut.dllOff == $past(cmdIn.addr[0])) else $error("dll off wrong");
  c_chop: cover property ($rose(dqOe[0]) && chop);
  c_dll_off_read: cover property (rd && modeOut.dllOff);
  c_refused: cover property (illegalInMpr);
endmodule // dmdc_mode_ctrl_monitor

bind dmdc_mode_ctrl dmdc_mode_ctrl_monitor u_dmdc_mode_ctrl_monitor
(
  .core_clk         (core_clk),
  .resetn           (resetn),
  .cmdIn            (cmdIn),
  .cke              (cke),
  .mprReplicate     (mprReplicate),
  .dqOut            (dqOut),
  .dqOe             (dqOe),
  .modeOut          (modeOut),
  .arrayReadStart   (arrayReadStart),
  .arrayWriteStart  (arrayWriteStart),
  .autoPrechargeReq (autoPrechargeReq),
  .illegalInMpr     (illegalInMpr)
);

// ===== tb/dmdc_ctrl_model.sv
`timescale 1ns/1ps
`include "dmdc_defs.svh"
module dmdc_ctrl_model
(
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic                go,
  input  wire dmdc_pkg::dmdc_cmd_t goCmd,
  output      dmdc_pkg::dmdc_cmd_t cmdIn
);
  logic                mprOn;
  dmdc_pkg::dmdc_cmd_t nextCmd;
  // readout reads always carry column bits 1:0 as zero
  always_comb
  begin
    nextCmd = goCmd;
    if (mprOn && goCmd[22:19] == `DMDC_CMD_READ)
      nextCmd.addr[1:0] = 2'h0;
  end
  // idle is deselect with the other lines toggling, so nothing stale can decode
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cmdIn <= '1;
      mprOn <= 1'b0;
    end
    else if (!go)
      cmdIn <= {1'b1, ~cmdIn[21:0]};
    else
    begin
      cmdIn <= nextCmd;
      if (goCmd[22:19] == `DMDC_CMD_MRS && goCmd.bank == `DMDC_MR3)
        mprOn <= goCmd.addr[`DMDC_A_MPREN];
    end
  end
endmodule // dmdc_ctrl_model

// ===== tb/dmdc_mode_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "dmdc_defs.svh"
module dmdc_mode_ctrl_tb_top;
  logic                 core_clk = 1'b0;
  logic                 resetn = 1'b0;
  logic                 cke = 1'b0;
  logic                 mprReplicate = 1'b0;
  logic                 go = 1'b0;
  dmdc_pkg::dmdc_cmd_t  goCmd = '1;
  dmdc_pkg::dmdc_cmd_t  cmdIn;
  dmdc_pkg::dmdc_mode_t modeOut;
  logic [15:0]          dqOut;
  logic [15:0]          dqOe;
  logic                 dqsOe;
  logic                 ard;
  logic                 awr;
  logic                 aps;
  logic                 drst;
  logic                 lun;
  logic                 ill;
  logic                 ch;
  logic [1:0]           expLoc = 2'h0;
  int                   mismatches;
  int                   samples_checked;
  int                   cyc;
  int                   beat;
  int                   nRd;
  int                   nWr;
  int                   nAp;
  int                   nRst;
  int                   nIll;
  int                   nBeat;
  // wait counts in clocks, plain defaults for this bench
  localparam int        T_MOD   = 12;
  localparam int        T_CKSRX = 10;
  localparam int        T_XS    = 20;
  always #4 core_clk = ~core_clk;
  dmdc_ctrl_model u_dmdc_ctrl_model
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .go       (go),
    .goCmd    (goCmd),
    .cmdIn    (cmdIn)
  );
  dmdc_mode_ctrl u_dmdc_mode_ctrl
  (
    .core_clk           (core_clk),
    .resetn             (resetn),
    .cmdIn              (cmdIn),
    .cke                (cke),
    .mprReplicate       (mprReplicate),
    .dqOut              (dqOut),
    .dqOe               (dqOe),
    .dqsOe              (dqsOe),
    .modeOut            (modeOut),
    .arrayReadStart     (ard),
    .arrayWriteStart    (awr),
    .autoPrechargeReq   (aps),
    .dllResetPulse      (drst),
    .latencyUnsupported (lun),
    .illegalInMpr       (ill)
  );
  function automatic logic [15:0] expWord(input int b);
    return (expLoc == 2'h0 && b[0]) ? (mprReplicate ? 16'hFFFF : 16'h0101) : 16'h0000;
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic issue(input logic [3:0] op, input logic [2:0] bk, input logic [15:0] ad);
    @(posedge core_clk);
    go <= 1'b1;
    goCmd <= {op, bk, ad};
    @(posedge core_clk);
    go <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic rdChk(input logic [15:0] ad, input int n, input int ap);
    int b0;
    int a0;
    b0 = nBeat;
    a0 = nAp;
    mprReplicate <= 1'($urandom);
    issue(`DMDC_CMD_READ, 3'($urandom), ad);
    issue(`DMDC_CMD_NOP, 3'h0, 16'h0000);
    repeat (16) @(posedge core_clk);
    chk(nBeat - b0, n);
    chk(nAp - a0, ap);
  endtask
  // self refresh round trip around each dll switch; the clock is only held, not retuned
  task automatic selfRefresh();
    cke <= 1'b0;
    issue(`DMDC_CMD_REF, 3'h0, 16'h0000);
    repeat (T_CKSRX) @(posedge core_clk);
    cke <= 1'b1;
    repeat (T_XS) @(posedge core_clk);
  endtask
  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    nRd = nRd + (ard === 1'b1);
    nWr = nWr + (awr === 1'b1);
    nAp = nAp + (aps === 1'b1);
    nRst = nRst + (drst === 1'b1);
    nIll = nIll + (ill === 1'b1);
    if (dqOe[0] === 1'b1)
    begin
      chk({dqsOe, dqOe}, 17'h1FFFF);
      chk(dqOut, expWord(beat));
      beat = beat + 1;
      nBeat = nBeat + 1;
    end
    else
      beat = 0;
    if (cyc == 4000)
    begin
      mismatches = mismatches + 1;
      final_report();
    end
  end
  initial
  begin
    void'($urandom(32'h97772615));
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    cke <= 1'b1;
    @(posedge core_clk);
    chk(modeOut, 16'h0060);
    rdChk(16'h0400, 0, 1);
    cke <= 1'b0;
    issue(`DMDC_CMD_WRITE, 3'h0, 16'h0000);
    cke <= 1'b1;
    issue(`DMDC_CMD_WRITE, 3'h0, 16'h0000);
    chk({nRd[3:0], nWr[3:0]}, 8'h11);
    for (int bl = 0; bl < 3; bl++)
    begin
      // burst setting changes only with readout mode off
      issue(`DMDC_CMD_MRS, `DMDC_MR3, 16'h0000);
      issue(`DMDC_CMD_MRS, `DMDC_MR0, 16'h0060 | 16'(bl));
      issue(`DMDC_CMD_MRS, `DMDC_MR3, 16'h0004);
      for (int k = 0; k < 4; k++)
      begin
        ch = bl == 2 || (bl == 1 && !k[0]);
        if (ch || !k[1])
          rdChk({3'h0, k[0], 9'h0, k[1], 2'h0} | (16'($urandom) & 16'hEFF8), ch ? 4 : 8, 0);
      end
    end
    issue(`DMDC_CMD_WRITE, 3'h0, 16'h0000);
    chk({nIll[3:0], nWr[3:0]}, 8'h11);
    for (int l = 1; l < 4; l++)
    begin
      expLoc = 2'(l);
      issue(`DMDC_CMD_MRS, `DMDC_MR3, 16'h0004 | 16'(l));
      rdChk(16'h0000, 4, 0);
    end
    issue(`DMDC_CMD_MRS, `DMDC_MR3, 16'h0000);
    issue(`DMDC_CMD_MRS, `DMDC_MR1, 16'h0001);
    repeat (T_MOD) @(posedge core_clk);
    selfRefresh();
    chk({modeOut.dllOff, lun}, 2'h2);
    rdChk(16'h0000, 0, 0);
    chk(nRd, 2);
    issue(`DMDC_CMD_MRS, `DMDC_MR0, 16'h0052);
    chk(lun, 1'h1);
    selfRefresh();
    issue(`DMDC_CMD_MRS, `DMDC_MR1, 16'h0000);
    issue(`DMDC_CMD_MRS, `DMDC_MR0, 16'h0160);
    chk({modeOut.dllOff, lun, nRst[3:0]}, 6'h01);
    final_report();
  end
endmodule // dmdc_mode_ctrl_tb_top
